// [bench/mpd_regs_bench.sv]
// Self-checking bench for the call-timing parameters, line voltage and window
`timescale 1ns/1ps
`include "mpd_defines.svh"
module mpd_regs_bench import mpd_pkg::*;;
   localparam int TK = 4;
   localparam logic [7:0] IDX[14] = '{`MPD_IDX_CRT, `MPD_IDX_CWT, `MPD_IDX_ATD, `MPD_IDX_CALLER_ID_GAIN_SEL,
      `MPD_IDX_RING, `MPD_IDX_INTR, `MPD_IDX_DGAIN, `MPD_IDX_CF1, `MPD_IDX_IOA, `MPD_IDX_IOB,
      `MPD_IDX_IODIR, `MPD_IDX_CF5, `MPD_IDX_TEST, `MPD_IDX_WMODE};
   localparam logic [7:0] RST[14] = '{`MPD_RST_CRT, `MPD_RST_CWT, `MPD_RST_ATD, `MPD_RST_CALLER_ID_GAIN_SEL,
      `MPD_RST_RING, `MPD_RST_INTR, `MPD_RST_DGAIN, `MPD_RST_CF1, `MPD_RST_IOA, `MPD_RST_IOB,
      `MPD_RST_IODIR, `MPD_RST_CF5, `MPD_RST_TEST, `MPD_RST_WMODE};
   // Edges of the dead zone and the sign bit
   localparam logic [7:0] LVE[6] = '{8'hfd, 8'hfe, 8'h02, 8'h03, 8'h80, 8'h7f};
   logic pclk, presetn, psel, penable, pwrite;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr;
   logic carrier_det_pin, call_start, answer_mode, off_hook;
   logic [7:0] line_volt, dsp_status;
   logic carrier_ok, call_abort, tone_en;
   mpd_win_s win;
   mpd_cfg_s cfg;
   int miscompares = 0;
   int comparisons = 0;
   int dstb = 0;
   int cstb = 0;
   int aborts = 0;
   logic [32:0] expq[$];

   mpd_regs #(.CRT_TICK_CYC(TK), .CWT_TICK_CYC(TK), .ATD_TICK_CYC(TK)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .carrier_det_pin(carrier_det_pin), .call_start(call_start),
      .answer_mode(answer_mode), .off_hook(off_hook), .line_volt(line_volt), .dsp_status(dsp_status),
      .carrier_ok(carrier_ok), .call_abort(call_abort), .tone_en(tone_en), .win(win), .cfg(cfg));

   always #2 pclk = ~pclk;

   // ----------------------------------------
   // Checking and reporting
   // ----------------------------------------
   task automatic end_sim();
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic check(input logic [79:0] s, input logic [79:0] e);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   // Read results are taken at the completing edge, oldest note first
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (expq.size() == 0) check(1, 0);
         else check({pslverr, prdata}, expq.pop_front());
      end
      if (win.data_stb === 1'b1) dstb++;
      if (win.ctrl_stb === 1'b1) cstb++;
      if (call_abort === 1'b1) aborts++;
   end

   // ----------------------------------------
   // APB master
   // ----------------------------------------
   function automatic logic [9:0] ba(input logic [7:0] i);
      return {i, 2'b00};
   endfunction

   // Ends with an idle cycle so a following call never reassigns psel in the same step
   task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         end_sim();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask

   task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic err);
      expq.push_back({err, 24'h0, e});
      apb(1'b0, a, 32'h0);
   endtask

   function automatic logic sig(input int k);
      case (k)
         0: return carrier_ok;
         1: return call_abort;
         default: return tone_en;
      endcase
   endfunction

   task automatic wait_for(input int k, input logic lvl, output int n);
      n = 0;
      while (sig(k) !== lvl && n < 300) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 300) begin
         miscompares++;
         end_sim();
      end
   endtask

   function automatic mpd_cfg_s cfgx(input logic [7:0] a[14]);
      return {a[3], a[4], a[5], a[6], a[7], a[8], a[9], a[10], a[11], a[12]};
   endfunction

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [7:0] v[14];
      logic [7:0] lv, a, b, c, d, e, f, g;
      int n;
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 10'h000;
      pwdata = 32'h0;
      carrier_det_pin = 1'b0;
      call_start = 1'b0;
      answer_mode = 1'b0;
      off_hook = 1'b0;
      line_volt = 8'h00;
      dsp_status = 8'h00;
      void'($urandom(8));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check(cfg, cfgx(RST));
      for (int i = 0; i < 14; i++) rd(ba(IDX[i]), RST[i], 1'b0);
      for (int i = 0; i < 14; i++) begin
         v[i] = 8'($urandom);
         wr(ba(IDX[i]), v[i]);
      end
      for (int i = 0; i < 14; i++) rd(ba(IDX[i]), v[i], 1'b0);
      check(cfg, cfgx(v));
      rd(10'h0e0, 8'h00, 1'b1);
      rd(10'h0dd, 8'h00, 1'b1);
      // Line voltage, a write to it must not disturb the reading
      wr(ba(`MPD_IDX_LVR), 8'h55);
      for (int i = 0; i < 12; i++) begin
         lv = (i < 6) ? LVE[i] : 8'($urandom);
         line_volt <= lv;
         repeat (3) @(posedge pclk);
         rd(ba(`MPD_IDX_LVR), ($signed(lv) > -3 && $signed(lv) < 3) ? 8'h00 : lv, 1'b0);
      end
      // Window in each mode
      a = 8'($urandom);
      b = 8'($urandom);
      c = 8'($urandom);
      d = 8'($urandom);
      e = 8'($urandom);
      f = 8'($urandom);
      g = 8'($urandom);
      wr(ba(`MPD_IDX_WMODE), `MPD_MODE_ADDR);
      wr(ba(`MPD_IDX_WLO), a);
      wr(ba(`MPD_IDX_WHI), b);
      check(win.addr, {b, a});
      rd(ba(`MPD_IDX_WLO), 8'h00, 1'b0);
      wr(ba(`MPD_IDX_WMODE), `MPD_MODE_DATA);
      wr(ba(`MPD_IDX_WLO), c);
      wr(ba(`MPD_IDX_WHI), d);
      check({win.addr, win.data}, {b, a, d[5:0], c});
      // Strobe counter moves on the same edge the write returns on
      @(posedge pclk);
      check(dstb, 1);
      dsp_status <= e;
      wr(ba(`MPD_IDX_WMODE), `MPD_MODE_CTRL);
      wr(ba(`MPD_IDX_WLO), f);
      wr(ba(`MPD_IDX_WHI), g);
      check({win.ctrl_lo, win.ctrl_hi, win.data}, {f, g, d[5:0], c});
      @(posedge pclk);
      check(cstb, 2);
      rd(ba(`MPD_IDX_WLO), e, 1'b0);
      rd(ba(`MPD_IDX_WHI), 8'h00, 1'b0);
      for (int m = 0; m < 2; m++) begin
         wr(ba(`MPD_IDX_WMODE), m ? 8'h80 : 8'h03);
         wr(ba(`MPD_IDX_WLO), ~f);
         wr(ba(`MPD_IDX_WHI), ~g);
         check({win.addr, win.data, win.ctrl_lo, win.ctrl_hi}, {b, a, d[5:0], c, f, g});
         @(posedge pclk);
         check({dstb, cstb}, {32'd1, 32'd2});
         rd(ba(`MPD_IDX_WLO), 8'h00, 1'b0);
      end
      // Carrier qualification, a drop mid-count restarts it
      wr(ba(`MPD_IDX_CRT), 8'h03);
      carrier_det_pin <= 1'b1;
      repeat (8) @(posedge pclk);
      check(carrier_ok, 1'b0);
      carrier_det_pin <= 1'b0;
      repeat (3) @(posedge pclk);
      carrier_det_pin <= 1'b1;
      wait_for(0, 1'b1, n);
      check(n >= 3 * TK && n <= 3 * TK + 8, 1'b1);
      // Carrier present during the wait: no abort
      wr(ba(`MPD_IDX_CWT), 8'h02);
      call_start <= 1'b1;
      @(posedge pclk);
      call_start <= 1'b0;
      repeat (30) @(posedge pclk);
      check(aborts, 0);
      carrier_det_pin <= 1'b0;
      wait_for(0, 1'b0, n);
      check(n <= 4, 1'b1);
      call_start <= 1'b1;
      @(posedge pclk);
      call_start <= 1'b0;
      wait_for(1, 1'b1, n);
      check(n >= 2 * TK - 1 && n <= 2 * TK + 8, 1'b1);
      repeat (4) @(posedge pclk);
      check(aborts, 1);
      // Answer tone only in answer mode while off-hook
      wr(ba(`MPD_IDX_ATD), 8'h02);
      off_hook <= 1'b1;
      repeat (30) @(posedge pclk);
      check(tone_en, 1'b0);
      answer_mode <= 1'b1;
      wait_for(2, 1'b1, n);
      check(n >= 2 * TK && n <= 2 * TK + 8, 1'b1);
      off_hook <= 1'b0;
      wait_for(2, 1'b0, n);
      check(n <= 3, 1'b1);
      check(expq.size(), 0);
      end_sim();
   end
endmodule // mpd_regs_bench

// [hdl/mpd_defines.svh]
// Register indices, reset values, window modes and timing for the parameter bank
`ifndef MPD_DEFINES_SVH
`define MPD_DEFINES_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define MPD_IDX_CRT 8'h37
`define MPD_IDX_CWT 8'h39
`define MPD_IDX_ATD 8'h3a
`define MPD_IDX_CALLER_ID_GAIN_SEL 8'h3c
`define MPD_IDX_RING 8'h62
`define MPD_IDX_INTR 8'h82
`define MPD_IDX_LVR 8'hdb
`define MPD_IDX_DGAIN 8'hdf
`define MPD_IDX_CF1 8'he0
`define MPD_IDX_IOA 8'he1
`define MPD_IDX_IOB 8'he2
`define MPD_IDX_IODIR 8'he3
`define MPD_IDX_CF5 8'he4
`define MPD_IDX_WLO 8'he5
`define MPD_IDX_WHI 8'he6
`define MPD_IDX_WMODE 8'he8
`define MPD_IDX_TEST 8'heb

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MPD_RST_CRT 8'h20
`define MPD_RST_CWT 8'h1e
`define MPD_RST_ATD 8'h29
`define MPD_RST_CALLER_ID_GAIN_SEL 8'h01
`define MPD_RST_RING 8'h41
`define MPD_RST_INTR 8'h08
`define MPD_RST_DGAIN 8'h0c
`define MPD_RST_CF1 8'h22
`define MPD_RST_IOA 8'h0e
`define MPD_RST_IOB 8'h00
`define MPD_RST_IODIR 8'h00
`define MPD_RST_CF5 8'h00
`define MPD_RST_WMODE 8'h00
`define MPD_RST_TEST 8'h00

// ----------------------------------------
// Window modes and line voltage floor
// ----------------------------------------
`define MPD_MODE_ADDR 8'h00
`define MPD_MODE_DATA 8'h01
`define MPD_MODE_CTRL 8'h02
`define MPD_LV_MIN_V 8'h03

// ----------------------------------------
// Timing
// ----------------------------------------
`define MPD_PCLK_NS 4
`define MPD_CRT_TICK_MS_NUM 5
`define MPD_CRT_TICK_MS_DEN 3
`define MPD_ATD_TICK_US_X1000 53330000
`define MPD_CWT_TICK_S 1
`define MPD_CRT_TICK_CYC ((`MPD_CRT_TICK_MS_NUM * 1000000) / (`MPD_CRT_TICK_MS_DEN * `MPD_PCLK_NS))
`define MPD_ATD_TICK_CYC (`MPD_ATD_TICK_US_X1000 / `MPD_PCLK_NS)
`define MPD_CWT_TICK_CYC ((`MPD_CWT_TICK_S * 1000000000) / `MPD_PCLK_NS)

`endif

// [hdl/mpd_pkg.sv]
// Types shared by the parameter bank and its timers
package mpd_pkg;

   typedef enum logic [1:0] {WIN_ADDR, WIN_DATA, WIN_CTRL, WIN_OFF} mpd_win_e;

   typedef enum logic {CALL_IDLE, CALL_WAIT} mpd_call_e;

   typedef struct packed {
      logic [15:0] addr;
      logic [13:0] data;
      logic [7:0] ctrl_lo;
      logic [7:0] ctrl_hi;
      logic data_stb;
      logic ctrl_stb;
   } mpd_win_s;

   typedef struct packed {
      logic [7:0] cid_gain;
      logic [7:0] ring;
      logic [7:0] intrusion;
      logic [7:0] dgain;
      logic [7:0] cf1;
      logic [7:0] io_a;
      logic [7:0] io_b;
      logic [7:0] io_dir;
      logic [7:0] cf5;
      logic [7:0] test;
   } mpd_cfg_s;

endpackage

// [hdl/mpd_regs.sv]
// Modem call-timing parameters, line voltage reading and signal processor window
//
// Operation
// RQ1 - Carrier counts as returned after continuous detection for programmed 5/3 ms ticks.
// RQ2 - Call waits for carrier at most programmed one-second ticks, then aborts.
// RQ3 - Answer tone starts after off-hook delay of programmed 53.33 ms ticks.
// RQ4 - Line voltage reads as signed eight-bit volts, sign giving polarity.
// RQ5 - Line voltage reads zero while magnitude is below three volts.
// RQ6 - Window mode register chooses meaning of the two window registers.
// RQ7 - Mode 0x00: window writes load target address low and high bytes.
// RQ8 - Mode 0x01: window writes load fourteen-bit data word low and high.
// RQ9 - Mode 0x02: low read gives status; low and high writes load control.
// RQ10 - Other modes: window writes ignored, window reads return zero.
`timescale 1ns/1ps
`include "mpd_defines.svh"
module mpd_regs import mpd_pkg::*; #(
   parameter int unsigned CRT_TICK_CYC = `MPD_CRT_TICK_CYC,
   parameter int unsigned CWT_TICK_CYC = `MPD_CWT_TICK_CYC,
   parameter int unsigned ATD_TICK_CYC = `MPD_ATD_TICK_CYC
) (
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB write
   input wire logic [9:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error, unmapped address
   input wire logic carrier_det_pin, // Carrier detect from line side
   input wire logic call_start, // Pulse: dialing begins
   input wire logic answer_mode, // Level: answering a call
   input wire logic off_hook, // Level: line is off-hook
   input wire logic [7:0] line_volt, // Signed tip-ring volts from converter
   input wire logic [7:0] dsp_status, // Signal processor status byte
   output logic carrier_ok, // Carrier qualified as present
   output logic call_abort, // Pulse: no carrier in time
   output logic tone_en, // Answer tone may sound
   output mpd_win_s win, // Window target address, data, control
   output mpd_cfg_s cfg // Bit-mapped configuration bytes
);

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   logic setup;
   logic acc;
   logic wr;
   logic [7:0] idx;
   logic rd_hit;
   logic [7:0] rd8;
   logic [7:0] crt_reg;
   logic [7:0] cwt_reg;
   logic [7:0] atd_reg;
   logic [7:0] mode_reg;
   logic [7:0] lvr_reg;
   mpd_win_e win_sel;

   assign setup = psel && !penable;
   assign acc = psel && penable && pready;
   assign idx = paddr[9:2];
   assign wr = acc && pwrite && rd_hit;

   always_comb begin
      case (mode_reg)
         `MPD_MODE_ADDR: win_sel = WIN_ADDR;
         `MPD_MODE_DATA: win_sel = WIN_DATA;
         `MPD_MODE_CTRL: win_sel = WIN_CTRL;
         default: win_sel = WIN_OFF;
      endcase
   end

   always_comb begin
      rd_hit = (paddr[1:0] == 2'b00);
      rd8 = 8'h00;
      case (idx)
         `MPD_IDX_CRT: rd8 = crt_reg;
         `MPD_IDX_CWT: rd8 = cwt_reg;
         `MPD_IDX_ATD: rd8 = atd_reg;
         `MPD_IDX_CALLER_ID_GAIN_SEL: rd8 = cfg.cid_gain;
         `MPD_IDX_RING: rd8 = cfg.ring;
         `MPD_IDX_INTR: rd8 = cfg.intrusion;
         `MPD_IDX_LVR: rd8 = lvr_reg;
         `MPD_IDX_DGAIN: rd8 = cfg.dgain;
         `MPD_IDX_CF1: rd8 = cfg.cf1;
         `MPD_IDX_IOA: rd8 = cfg.io_a;
         `MPD_IDX_IOB: rd8 = cfg.io_b;
         `MPD_IDX_IODIR: rd8 = cfg.io_dir;
         `MPD_IDX_CF5: rd8 = cfg.cf5;
         `MPD_IDX_WLO: rd8 = (win_sel == WIN_CTRL) ? dsp_status : 8'h00; // see RQ9 see RQ10
         `MPD_IDX_WHI: rd8 = 8'h00;
         `MPD_IDX_WMODE: rd8 = mode_reg;
         `MPD_IDX_TEST: rd8 = cfg.test;
         default: rd_hit = 1'b0;
      endcase
   end

   // Answer is always one cycle after setup; data sampled at setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         if (setup) begin
            prdata <= {24'h0, rd_hit ? rd8 : 8'h00};
            pslverr <= !rd_hit;
         end
      end
   end

   // ----------------------------------------
   // Parameter and configuration registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crt_reg <= `MPD_RST_CRT; // see RQ1
         cwt_reg <= `MPD_RST_CWT;
         atd_reg <= `MPD_RST_ATD; // see RQ3
      end else if (wr) begin
         case (idx)
            `MPD_IDX_CRT: crt_reg <= pwdata[7:0];
            `MPD_IDX_CWT: cwt_reg <= pwdata[7:0];
            `MPD_IDX_ATD: atd_reg <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= '{`MPD_RST_CALLER_ID_GAIN_SEL, `MPD_RST_RING, `MPD_RST_INTR, `MPD_RST_DGAIN, `MPD_RST_CF1,
                  `MPD_RST_IOA, `MPD_RST_IOB, `MPD_RST_IODIR, `MPD_RST_CF5, `MPD_RST_TEST};
      end else if (wr) begin
         case (idx)
            `MPD_IDX_CALLER_ID_GAIN_SEL: cfg.cid_gain <= pwdata[7:0];
            `MPD_IDX_RING: cfg.ring <= pwdata[7:0];
            `MPD_IDX_INTR: cfg.intrusion <= pwdata[7:0];
            `MPD_IDX_DGAIN: cfg.dgain <= pwdata[7:0];
            `MPD_IDX_CF1: cfg.cf1 <= pwdata[7:0];
            `MPD_IDX_IOA: cfg.io_a <= pwdata[7:0];
            `MPD_IDX_IOB: cfg.io_b <= pwdata[7:0];
            `MPD_IDX_IODIR: cfg.io_dir <= pwdata[7:0];
            `MPD_IDX_CF5: cfg.cf5 <= pwdata[7:0];
            `MPD_IDX_TEST: cfg.test <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Signal processor window
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= `MPD_RST_WMODE;
      end else if (wr && idx == `MPD_IDX_WMODE) begin
         mode_reg <= pwdata[7:0]; // see RQ6
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win <= '0;
      end else begin
         win.data_stb <= 1'b0;
         win.ctrl_stb <= 1'b0;
         if (wr && (idx == `MPD_IDX_WLO || idx == `MPD_IDX_WHI)) begin
            case (win_sel)
               WIN_ADDR: begin
                  if (idx == `MPD_IDX_WLO) begin
                     win.addr[7:0] <= pwdata[7:0]; // see RQ7
                  end else begin
                     win.addr[15:8] <= pwdata[7:0]; // see RQ7
                  end
               end
               WIN_DATA: begin
                  if (idx == `MPD_IDX_WLO) begin
                     win.data[7:0] <= pwdata[7:0]; // see RQ8
                  end else begin
                     win.data[13:8] <= pwdata[5:0]; // see RQ8
                     win.data_stb <= 1'b1;
                  end
               end
               WIN_CTRL: begin
                  if (idx == `MPD_IDX_WLO) begin
                     win.ctrl_lo <= pwdata[7:0]; // see RQ9
                  end else begin
                     win.ctrl_hi <= pwdata[7:0]; // see RQ9
                  end
                  win.ctrl_stb <= 1'b1;
               end
               default: ; // see RQ10
            endcase
         end
      end
   end

   // ----------------------------------------
   // Line voltage reading
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvr_reg <= 8'h00;
      end else if ($signed(line_volt) < $signed(`MPD_LV_MIN_V) &&
                   $signed(line_volt) > $signed(8'h00 - `MPD_LV_MIN_V)) begin
         lvr_reg <= 8'h00; // see RQ5
      end else begin
         lvr_reg <= line_volt; // see RQ4
      end
   end

   // ----------------------------------------
   // Carrier qualification and call timers
   // ----------------------------------------
   logic det_meta;
   logic det_s;
   logic cr_run;
   logic cr_done;
   logic cw_done;
   logic at_run;
   logic at_done;
   mpd_call_e call_st;

   // Line-side carrier input is asynchronous to pclk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         det_meta <= 1'b0;
         det_s <= 1'b0;
      end else begin
         det_meta <= carrier_det_pin;
         det_s <= det_meta;
      end
   end

   assign cr_run = det_s && !carrier_ok;
   assign at_run = answer_mode && off_hook;

   mpd_tick_timer #(.TICK_CYC(CRT_TICK_CYC)) u_return (
      .clk(pclk),
      .rst_n(presetn),
      .run(cr_run),
      .limit(crt_reg),
      .done(cr_done)
   );

   mpd_tick_timer #(.TICK_CYC(CWT_TICK_CYC)) u_wait (
      .clk(pclk),
      .rst_n(presetn),
      .run(call_st == CALL_WAIT),
      .limit(cwt_reg),
      .done(cw_done)
   );

   mpd_tick_timer #(.TICK_CYC(ATD_TICK_CYC)) u_tone (
      .clk(pclk),
      .rst_n(presetn),
      .run(at_run),
      .limit(atd_reg),
      .done(at_done)
   );

   // A drop in detection restarts the return count from zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         carrier_ok <= 1'b0;
      end else if (!det_s) begin
         carrier_ok <= 1'b0;
      end else if (cr_done) begin
         carrier_ok <= 1'b1; // see RQ1
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         call_st <= CALL_IDLE;
         call_abort <= 1'b0;
      end else begin
         call_abort <= 1'b0;
         case (call_st)
            CALL_IDLE: begin
               if (call_start) begin
                  call_st <= CALL_WAIT;
               end
            end
            CALL_WAIT: begin
               if (det_s) begin
                  call_st <= CALL_IDLE;
               end else if (cw_done) begin
                  call_abort <= 1'b1; // see RQ2
                  call_st <= CALL_IDLE;
               end
            end
            default: call_st <= CALL_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tone_en <= 1'b0;
      end else begin
         tone_en <= at_run && at_done; // see RQ3
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   lv_small_zero_a: assert property ( // see RQ5
      ($signed(line_volt) < 3 && $signed(line_volt) > -3) |=> lvr_reg == 8'h00)
      else $error("line voltage below floor not zero");
   lv_pass_a: assert property ( // see RQ4
      ($signed(line_volt) >= 3 || $signed(line_volt) <= -3) |=> lvr_reg == $past(line_volt))
      else $error("line voltage not passed through");
   mode_write_a: assert property ( // see RQ6
      (wr && idx == `MPD_IDX_WMODE) |=> mode_reg == $past(pwdata[7:0]))
      else $error("window mode not loaded");
   win_addr_a: assert property ( // see RQ7
      (wr && idx == `MPD_IDX_WHI && mode_reg == 8'h00) |=> win.addr[15:8] == $past(pwdata[7:0]))
      else $error("window address high not loaded");
   win_data_a: assert property ( // see RQ8
      (wr && idx == `MPD_IDX_WHI && mode_reg == 8'h01)
      |=> win.data[13:8] == $past(pwdata[5:0]) && win.data_stb)
      else $error("window data high not loaded");
   win_status_a: assert property ( // see RQ9
      (setup && !pwrite && paddr == 10'h394 && mode_reg == 8'h02)
      |=> pready && prdata == {24'h0, $past(dsp_status)})
      else $error("window status read wrong");
   win_bad_mode_a: assert property ( // see RQ10
      (acc && (idx == `MPD_IDX_WLO || idx == `MPD_IDX_WHI) && mode_reg > 8'h02)
      |=> $stable(win.addr) && $stable(win.data) && $stable(win.ctrl_lo) && $stable(win.ctrl_hi))
      else $error("window changed in undefined mode");
   carrier_rise_a: assert property ( // see RQ1
      $rose(carrier_ok) |-> $past(det_s) && $past(det_s, 2) && $past(cr_done))
      else $error("carrier qualified without return count");
   call_abort_a: assert property ( // see RQ2
      call_abort |-> $past(call_st) == CALL_WAIT && $past(cw_done) && !$past(det_s) ##1 !call_abort)
      else $error("call abort without timeout");
   tone_start_a: assert property ( // see RQ3
      $rose(tone_en) |-> $past(at_done) && $past(answer_mode) && $past(off_hook))
      else $error("answer tone without delay");
   apb_answer_a: assert property (setup |=> pready ##1 !pready || setup)
      else $error("bus answer not one cycle");

   carrier_back_c: cover property ($rose(carrier_ok));
   call_abort_c: cover property (call_abort);
   tone_on_c: cover property ($rose(tone_en));
   win_ctrl_c: cover property (wr && idx == `MPD_IDX_WLO && win_sel == WIN_CTRL);

endmodule // mpd_regs

// [hdl/mpd_tick_timer.sv]
// Tick prescaler with an eight-bit tick counter compared against a limit
`timescale 1ns/1ps
module mpd_tick_timer import mpd_pkg::*; #(
   parameter int unsigned TICK_CYC = 4
) (
   input wire logic clk, // System clock
   input wire logic rst_n, // Async reset, active low
   input wire logic run, // Count while high, clear when low
   input wire logic [7:0] limit, // Ticks to reach
   output logic done // Limit reached while running
);

   logic [27:0] div_reg;
   logic [7:0] cnt_reg;
   logic tick;

   // Prescaler restarts with run so the first tick is a full period
   assign tick = run && (div_reg == 28'(TICK_CYC - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= 28'h0;
      end else if (!run || tick) begin
         div_reg <= 28'h0;
      end else begin
         div_reg <= div_reg + 28'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 8'h0;
      end else if (!run) begin
         cnt_reg <= 8'h0;
      end else if (tick && cnt_reg != 8'hff) begin
         cnt_reg <= cnt_reg + 8'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done <= 1'b0;
      end else begin
         done <= run && (cnt_reg >= limit);
      end
   end

endmodule // mpd_tick_timer
